// ==== include/twslv_defines.vh ====
/*
  register addresses, control bit positions, reset values and timing
  counts for the two-wire slave and software master block.
  assumes a 10 mhz core clock and 8-bit special-function access.
*/
`ifndef TWSLV_DEFINES_VH
`define TWSLV_DEFINES_VH

`define TWSLV_ADDR_DATA      8'h9a
`define TWSLV_ADDR_SLAVE     8'h9b
`define TWSLV_ADDR_CONTROL   8'he8

`define TWSLV_RST_DATA       8'h00
`define TWSLV_RST_SLAVE      8'h55
`define TWSLV_RST_CONTROL    8'h00

`define TWSLV_BIT_MDOUT      7
`define TWSLV_BIT_MDEN       6
`define TWSLV_BIT_MCOUT      5
`define TWSLV_BIT_MDIN       4
`define TWSLV_BIT_MSEL       3
`define TWSLV_BIT_SRST       2
`define TWSLV_BIT_DIR        1
`define TWSLV_BIT_DONE       0

`define TWSLV_IRQ_VECTOR     16'h003b
`define TWSLV_CLK_NS         100
`define TWSLV_SPIKE_NS       50
`define TWSLV_SPIKE_CYC      ((`TWSLV_SPIKE_NS + `TWSLV_CLK_NS - 1) / `TWSLV_CLK_NS)

`endif

// ==== logic/twslv_core.v ====
/*
  two-wire hardware slave plus software master through three registers.
  assumes a single-cycle register port from the core, and that the spi
  block owns the pins whenever spi_select_bit is high.
*/
// What this block does
// - spi select hands pins away from block
// - master data bit drives data pin
// - drive enable makes data pin output
// - master clock bit drives clock pin
// - data in captured at clock rise
// - control bit 3 selects master; reset slave
// - slave reset bit forces idle
// - direction flag loaded from read/write bit
// - address match raises byte done flag
// - data register access clears byte done
// - second access stalls slave until reset
// - interrupt needs both enables set
// - first byte shows address and direction
// - hold clock low while flag set
// - nack gives no flag, go idle
// - flag per acked byte until stop
// - stop condition returns slave to idle
// - slave address resets 55, writable
// - filter rejects spikes under 50 ns
// - no address versus data indication
`timescale 1ns/1ps
`include "twslv_defines.vh"
module twslv_core (
  input  wire       clk,               // core clock 10 mhz
  input  wire       reset_n,           // async reset, active low
  input  wire [7:0] reg_addr,          // register address
  input  wire       reg_wr,            // write strobe
  input  wire       reg_rd,            // read strobe
  input  wire [7:0] reg_wdata,         // write data
  output reg  [7:0] reg_rdata,         // read data, one cycle after rd
  input  wire       spi_select_bit,    // spi owns the pins when high
  input  wire       twowire_irq_enable,// two-wire interrupt enable
  input  wire       global_irq_enable, // global interrupt enable
  output reg        irq_request,       // interrupt request level
  input  wire       serial_data_in,    // data pin level
  output reg        serial_data_out,   // data pin drive value
  output reg        serial_data_oe_n,  // low while driving data pin
  input  wire       serial_clock_in,   // clock pin level
  output reg        serial_clock_out,  // clock pin drive value
  output reg        serial_clock_oe_n  // low while driving clock pin
);
  localparam ST_IDLE = 3'd0;
  localparam ST_RECV = 3'd1;
  localparam ST_ACK  = 3'd2;
  localparam ST_HOLD = 3'd3;
  localparam ST_SEND = 3'd4;
  localparam ST_RACK = 3'd5;
  localparam ST_STOP = 3'd6;

  reg  [7:0] twowire_data;
  reg  [7:0] twowire_slave_address;
  reg        master_data_out_bit;
  reg        master_data_drive_enable;
  reg        master_clock_out_bit;
  reg        master_data_in_bit;
  reg        master_select;
  reg        slave_reset_bit;
  reg        slave_direction_flag;
  reg        byte_done_flag;
  reg  [2:0] state;
  reg  [3:0] bit_count;
  reg        first_byte;
  reg        access_seen;
  reg        sda_drive_low;
  reg        scl_prev;
  reg        sda_prev;
  wire       sda;
  wire       scl;
  wire [7:0] shift_value;
  reg        shift_load;
  reg  [7:0] shift_load_val;
  reg        shift_in;

  // clean pin levels
  twslv_pin_filter u_sda_filter (
    .clk     (clk),
    .reset_n (reset_n),
    .pin_in  (serial_data_in),
    .level   (sda)
  );
  twslv_pin_filter u_scl_filter (
    .clk     (clk),
    .reset_n (reset_n),
    .pin_in  (serial_clock_in),
    .level   (scl)
  );

  twslv_shifter u_shift (
    .clk      (clk),
    .reset_n  (reset_n),
    .load     (shift_load),
    .load_val (shift_load_val),
    .shift    (shift_in),
    .bit_in   (sda),
    .value    (shift_value)
  );

  // register select decode, shared by the write and data access decodes; reads use a case on reg_addr
  function reg_sel;
    input [7:0] addr;
    input [7:0] which;
    begin
      reg_sel = (addr == which);
    end
  endfunction

  // bus events on filtered lines
  wire scl_rise  = scl & ~scl_prev;
  wire scl_fall  = ~scl & scl_prev;
  wire start_ev  = scl & scl_prev & sda_prev & ~sda;
  wire stop_ev   = scl & scl_prev & ~sda_prev & sda;
  wire slave_on  = ~spi_select_bit & ~master_select;
  wire data_hit  = reg_sel(reg_addr, `TWSLV_ADDR_DATA) & (reg_rd | reg_wr);
  wire data_wr   = reg_sel(reg_addr, `TWSLV_ADDR_DATA) & reg_wr;
  wire ctl_wr    = reg_sel(reg_addr, `TWSLV_ADDR_CONTROL) & reg_wr;
  wire slave_clr = slave_reset_bit | ~slave_on;
  wire addr_ok   = shift_value[7:1] == twowire_slave_address[6:0];
  // a data access with no flag pending stops the slave until reset
  wire stalled   = access_seen & ~byte_done_flag;

  // edge history of the filtered lines
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl;
      sda_prev <= sda;
    end
  end

  // software-writable registers
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      twowire_slave_address    <= `TWSLV_RST_SLAVE;
      master_data_out_bit      <= 1'b0;
      master_data_drive_enable <= 1'b0;
      master_clock_out_bit     <= 1'b0;
      master_select            <= 1'b0;
      slave_reset_bit          <= 1'b0;
    end else begin
      if (reg_sel(reg_addr, `TWSLV_ADDR_SLAVE) & reg_wr)
        twowire_slave_address <= reg_wdata;
      if (ctl_wr) begin
        master_data_out_bit      <= reg_wdata[`TWSLV_BIT_MDOUT];
        master_data_drive_enable <= reg_wdata[`TWSLV_BIT_MDEN];
        master_clock_out_bit     <= reg_wdata[`TWSLV_BIT_MCOUT];
        master_select            <= reg_wdata[`TWSLV_BIT_MSEL];
        slave_reset_bit          <= reg_wdata[`TWSLV_BIT_SRST];
      end
    end
  end

  // master data in sampled on filtered clock rise
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      master_data_in_bit <= 1'b0;
    else if (master_select & ~master_data_drive_enable & scl_rise)
      master_data_in_bit <= sda;
  end

  // shifter control
  always @* begin
    shift_load     = 1'b0;
    shift_load_val = twowire_data;
    shift_in       = 1'b0;
    if (state == ST_RECV && scl_rise)
      shift_in = 1'b1;
    if (data_wr && state == ST_HOLD) begin
      shift_load     = 1'b1;
      shift_load_val = reg_wdata;
    end
    // every send fall moves the next bit up from msb-1 to msb
    if (state == ST_SEND && scl_fall)
      shift_in = 1'b1;
  end

  // slave state machine
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state                <= ST_IDLE;
      bit_count            <= 4'd0;
      first_byte           <= 1'b0;
      byte_done_flag       <= 1'b0;
      slave_direction_flag <= 1'b0;
      twowire_data         <= `TWSLV_RST_DATA;
      access_seen          <= 1'b0;
      sda_drive_low        <= 1'b0;
    end else if (slave_clr) begin
      state          <= ST_IDLE;
      bit_count      <= 4'd0;
      byte_done_flag <= 1'b0;
      access_seen    <= 1'b0;
      sda_drive_low  <= 1'b0;
      if (data_wr)
        twowire_data <= reg_wdata;
    end else begin
      if (data_hit) begin
        byte_done_flag <= 1'b0;
        if (!byte_done_flag)
          access_seen <= 1'b1;
        if (data_wr)
          twowire_data <= reg_wdata;
      end
      if (stalled) begin
        // frozen after a double access; slave reset, master select or spi select frees it
        sda_drive_low <= 1'b0;
      end else if (stop_ev) begin
        state         <= ST_IDLE;
        sda_drive_low <= 1'b0;
      end else if (start_ev) begin
        state         <= ST_RECV;
        bit_count     <= 4'd0;
        first_byte    <= 1'b1;
        access_seen   <= 1'b0;
        sda_drive_low <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            sda_drive_low <= 1'b0;
          end
          ST_RECV: begin
            if (scl_rise)
              bit_count <= bit_count + 4'd1;
            if (scl_fall && bit_count == 4'd8) begin
              if (first_byte && !addr_ok) begin
                state <= ST_IDLE;
              end else begin
                sda_drive_low <= 1'b1;
                state         <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            // ack bit clocked out; set flag once its clock falls
            // an access in this same cycle counts as stale
            if (scl_fall) begin
              sda_drive_low  <= 1'b0;
              twowire_data   <= shift_value;
              byte_done_flag <= 1'b1;
              access_seen    <= 1'b0;
              if (first_byte)
                slave_direction_flag <= shift_value[0];
              state <= ST_HOLD;
            end
          end
          ST_HOLD: begin
            // wait for software; clock stays low meanwhile
            if (!byte_done_flag && !stalled) begin
              bit_count  <= 4'd0;
              first_byte <= 1'b0;
              if (slave_direction_flag) begin
                state         <= ST_SEND;
                sda_drive_low <= ~twowire_data[7];
              end else begin
                state <= ST_RECV;
              end
            end
          end
          ST_SEND: begin
            if (scl_fall) begin
              if (bit_count == 4'd7) begin
                sda_drive_low <= 1'b0;
                state         <= ST_RACK;
              end else begin
                bit_count     <= bit_count + 4'd1;
                sda_drive_low <= ~shift_value[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              if (sda)
                state <= ST_STOP;
              else
                state <= ST_ACK;
            end
          end
          ST_STOP: begin
            state <= ST_IDLE;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // pin drivers, all registered; spi owns pins when selected
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_data_out   <= 1'b1;
      serial_data_oe_n  <= 1'b1;
      serial_clock_out  <= 1'b1;
      serial_clock_oe_n <= 1'b1;
    end else if (spi_select_bit) begin
      serial_data_out   <= 1'b1;
      serial_data_oe_n  <= 1'b1;
      serial_clock_out  <= 1'b1;
      serial_clock_oe_n <= 1'b1;
    end else if (master_select) begin
      serial_data_out   <= master_data_out_bit;
      serial_data_oe_n  <= ~master_data_drive_enable;
      serial_clock_out  <= master_clock_out_bit;
      serial_clock_oe_n <= 1'b0;
    end else begin
      serial_data_out   <= 1'b0;
      serial_data_oe_n  <= ~sda_drive_low;
      serial_clock_out  <= 1'b0;
      // held low while waiting for software or while stalled
      serial_clock_oe_n <= ~((state == ST_HOLD) | stalled);
    end
  end

  // read data and interrupt request
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata   <= 8'h00;
      irq_request <= 1'b0;
    end else begin
      irq_request <= byte_done_flag & twowire_irq_enable
                     & global_irq_enable;
      if (reg_rd) begin
        case (reg_addr)
          `TWSLV_ADDR_DATA:    reg_rdata <= twowire_data;
          `TWSLV_ADDR_SLAVE:   reg_rdata <= twowire_slave_address;
          `TWSLV_ADDR_CONTROL: reg_rdata <= {master_data_out_bit,
                                 master_data_drive_enable,
                                 master_clock_out_bit, master_data_in_bit,
                                 master_select, slave_reset_bit,
                                 slave_direction_flag, byte_done_flag};
          default:             reg_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule // twslv_core

// ==== logic/twslv_pin_filter.v ====
/*
  synchroniser and glitch filter for one pin input.
  assumes the pin is asynchronous to clk; output is clean level.
*/
`timescale 1ns/1ps
module twslv_pin_filter (
  input  wire clk,      // core clock
  input  wire reset_n,  // async reset, active low
  input  wire pin_in,   // raw pin level
  output reg  level     // filtered level
);
  reg sync_a;
  reg sync_b;
  reg sync_c;

  // three stages; second and third must agree before a change counts
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      sync_c <= 1'b1;
      level  <= 1'b1;
    end else begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
      if (sync_b == sync_c)
        level <= sync_c;
    end
  end
endmodule // twslv_pin_filter

// ==== logic/twslv_shifter.v ====
/*
  eight-bit shift register with parallel load, shared by slave rx and tx.
  assumes load and shift are never asked together.
*/
`timescale 1ns/1ps
module twslv_shifter (
  input  wire       clk,      // core clock
  input  wire       reset_n,  // async reset, active low
  input  wire       load,     // parallel load pulse
  input  wire [7:0] load_val, // value to load
  input  wire       shift,    // shift-in pulse
  input  wire       bit_in,   // bit shifted in at lsb
  output reg  [7:0] value     // current contents, msb goes out first
);
  // load wins, else shift msb first
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      value <= 8'h00;
    else if (load)
      value <= load_val;
    else if (shift)
      value <= {value[6:0], bit_in};
  end
endmodule // twslv_shifter

// ==== tb/twslv_bus_model.sv ====
/* external bus master on the open-drain lines.
   assumes pull-ups in the bench; 1 on an output releases the line. */
`timescale 1ns/1ps
module twslv_bus_model (
  input  logic clk,   // pacing clock
  input  logic sda,   // resolved data line
  input  logic scl,   // resolved clock line
  output logic sda_o, // 0 pulls data low
  output logic scl_o  // 0 pulls clock low
);
  integer n;
  initial sda_o = 1'b1;
  initial scl_o = 1'b1;
  // third of a bit
  task q;
    repeat (4) @(negedge clk);
  endtask
  // release clock, wait out a stretch with a bound
  task hi;
    begin
      scl_o = 1'b1;
      n = 0;
      while (!scl && n < 400) begin
        @(negedge clk);
        n = n + 1;
      end
      q;
    end
  endtask
  // one bit: data set while clock low, sampled while high
  task bit_x(input logic b, output logic s);
    begin
      q;
      sda_o = b;
      q;
      hi;
      s = sda;
      scl_o = 1'b0;
    end
  endtask
  task start;
    begin
      sda_o = 1'b1;
      hi;
      sda_o = 1'b0;
      q;
      scl_o = 1'b0;
    end
  endtask
  task stop;
    begin
      q;
      sda_o = 1'b0;
      q;
      hi;
      sda_o = 1'b1;
      q;
    end
  endtask
  // eight bits msb first, then the acknowledge bit
  task xfer(input logic [7:0] d, input logic a,
            output logic [7:0] r, output logic k);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) bit_x(d[i], r[i]);
      bit_x(a, k);
    end
  endtask
endmodule // twslv_bus_model

// ==== tb/twslv_core_tb_top.sv ====
/* self-checking bench for the two-wire core.
   assumes the bus model on the pins and the bound checker. */
`timescale 1ns/1ps
module twslv_core_tb_top;
  logic       clk, reset_n, reg_wr, reg_rd, spi_select_bit, ak;
  logic       twowire_irq_enable, global_irq_enable, irq_request;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v, r, w;
  logic       serial_data_out, serial_data_oe_n, bm_sda, bm_scl;
  logic       serial_clock_out, serial_clock_oe_n;
  integer     bad_count = 0, tests_run = 0, i;
  // open-drain lines with pull-ups
  wire sda = bm_sda & (serial_data_oe_n | serial_data_out);
  wire scl = bm_scl & (serial_clock_oe_n | serial_clock_out);
  twslv_core dut_u (.clk, .reset_n, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .spi_select_bit, .twowire_irq_enable,
    .global_irq_enable, .irq_request, .serial_data_in(sda),
    .serial_data_out, .serial_data_oe_n, .serial_clock_in(scl),
    .serial_clock_out, .serial_clock_oe_n);
  twslv_bus_model bus_u (.clk, .sda, .scl, .sda_o(bm_sda), .scl_o(bm_scl));
  always #50 clk = ~clk;
  task give_verdict;
    if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    tests_run = tests_run + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge clk);
    reg_wr = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  // address byte out, wait for the flag to settle
  task adr(input logic [7:0] a, input logic e);
    bus_u.start;
    bus_u.xfer(a, 1'b1, r, ak);
    chk({7'h0, ak}, {7'h0, e});
    repeat (10) @(negedge clk);
  endtask
  task t_regs;
    rd(8'he8, v); chk(v, 8'h00);
    rd(8'h9b, v); chk(v, 8'h55);
    rd(8'h00, v); chk(v, 8'h00);
    wr(8'h9b, 8'h2a); rd(8'h9b, v); chk(v, 8'h2a);
    wr(8'h9b, 8'h55);
  endtask
  task t_master;
    for (i = 0; i < 3; i = i + 1) begin
      w = (i == 0) ? 8'hc8 : (i == 1) ? 8'h48 : 8'h28;
      wr(8'he8, w);
      chk({serial_data_oe_n, serial_clock_oe_n}, {~w[6], 1'b0});
      chk({7'h0, serial_clock_out}, {7'h0, w[5]});
      if (w[6]) chk({7'h0, serial_data_out}, {7'h0, w[7]});
    end
    for (i = 0; i < 2; i = i + 1) begin
      bus_u.sda_o = i[0];
      wr(8'he8, 8'h08); wr(8'he8, 8'h28);
      bus_u.sda_o = ~i[0];
      repeat (6) @(negedge clk);
      rd(8'he8, v); chk(v & 8'h10, {3'h0, i[0], 4'h0});
    end
    bus_u.sda_o = 1'b1;
    spi_select_bit = 1'b1;
    repeat (3) @(negedge clk);
    chk({serial_data_oe_n, serial_clock_oe_n}, 8'h03);
    spi_select_bit = 1'b0;
    wr(8'he8, 8'h00);
  endtask
  task t_slv_wr;
    {twowire_irq_enable, global_irq_enable} = 2'h3;
    adr(8'haa, 1'b0);
    chk({serial_clock_oe_n, irq_request}, 8'h01);
    rd(8'he8, v); chk(v & 8'h03, 8'h01);
    rd(8'h9a, v); chk(v, 8'haa);
    repeat (3) @(negedge clk);
    chk({serial_clock_oe_n, irq_request}, 8'h02);
    bus_u.xfer(8'h3c, 1'b1, r, ak);
    repeat (10) @(negedge clk);
    rd(8'h9a, v); chk(v, 8'h3c);
    bus_u.stop;
  endtask
  task t_slv_rd;
    adr(8'hab, 1'b0);
    rd(8'he8, v); chk(v & 8'h03, 8'h03);
    global_irq_enable = 1'b0;
    repeat (2) @(negedge clk);
    chk({7'h0, irq_request}, 8'h00);
    global_irq_enable = 1'b1;
    wr(8'h9a, 8'hc3);
    bus_u.xfer(8'hff, 1'b1, r, ak);
    chk(r, 8'hc3);
    repeat (10) @(negedge clk);
    rd(8'he8, v); chk(v & 8'h01, 8'h00);
    chk({7'h0, serial_clock_oe_n}, 8'h01);
    bus_u.stop;
    {twowire_irq_enable, global_irq_enable} = 2'h0;
  endtask
  task t_mism;
    adr(8'h24, 1'b1);
    chk({7'h0, serial_clock_oe_n}, 8'h01);
    bus_u.stop;
  endtask
  task t_stall;
    adr(8'haa, 1'b0);
    rd(8'h9a, v); chk(v, 8'haa);
    repeat (6) @(negedge clk);
    rd(8'h9a, v);
    repeat (10) @(negedge clk);
    chk({7'h0, serial_clock_oe_n}, 8'h00);
    wr(8'he8, 8'h04);
    repeat (6) @(negedge clk);
    chk({serial_data_oe_n, serial_clock_oe_n}, 8'h03);
    wr(8'he8, 8'h00);
    bus_u.stop;
    adr(8'haa, 1'b0);
    rd(8'h9a, v); chk(v, 8'haa);
    bus_u.stop;
  endtask
  // cut a hang short
  initial begin
    #2000000;
    bad_count = bad_count + 1;
    give_verdict;
  end
  initial begin
    {clk, reset_n, reg_wr, reg_rd, spi_select_bit} = 5'h00;
    {twowire_irq_enable, global_irq_enable} = 2'h0;
    {reg_addr, reg_wdata} = 16'h0000;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    t_regs;
    t_master;
    t_slv_wr;
    t_slv_rd;
    t_mism;
    t_stall;
    give_verdict;
  end
endmodule // twslv_core_tb_top

// ==== tb/twslv_properties.sv ====
/* port-level checker for the two-wire core.
   assumes it is bound onto twslv_core and sees resolved pin levels. */
`timescale 1ns/1ps
module twslv_properties (
  input logic       clk,                // core clock
  input logic       reset_n,            // async reset
  input logic [7:0] reg_addr,           // register address
  input logic       reg_wr,             // write strobe
  input logic       reg_rd,             // read strobe
  input logic [7:0] reg_wdata,          // write data
  input logic       spi_select_bit,     // spi owns pins
  input logic       twowire_irq_enable, // local enable
  input logic       global_irq_enable,  // global enable
  input logic       irq_request,        // irq level
  input logic       serial_data_in,     // data line
  input logic       serial_data_out,    // data drive
  input logic       serial_data_oe_n,   // data enable
  input logic       serial_clock_in,    // clock line
  input logic       serial_clock_out,   // clock drive
  input logic       serial_clock_oe_n   // clock enable
);
  logic [7:0] ctl;
  logic       m_on;
  logic       d_acc;
  logic       en;
  // decoded mode, data access and interrupt enables
  assign m_on = ctl[3] && !spi_select_bit;
  assign d_acc = (reg_rd || reg_wr) && reg_addr == 8'h9a;
  assign en = twowire_irq_enable && global_irq_enable;
  // shadow of what software wrote to control
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n) ctl <= 8'h00;
    else if (reg_wr && reg_addr == 8'he8) ctl <= reg_wdata;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_spi;
    spi_select_bit[*2] |-> serial_data_oe_n && serial_clock_oe_n;
  endproperty
  a_spi: assert property (p_spi) else $error("pins kept");
  property p_mclk;
    (m_on && $stable(ctl))[*3] |->
      !serial_clock_oe_n && serial_clock_out == ctl[5];
  endproperty
  a_mclk: assert property (p_mclk) else $error("clock pin");
  property p_mdat;
    (m_on && $stable(ctl))[*3] |-> serial_data_oe_n == !ctl[6] &&
      (!ctl[6] || serial_data_out == ctl[7]);
  endproperty
  a_mdat: assert property (p_mdat) else $error("data pin");
  property p_irq;
    irq_request |-> $past(en);
  endproperty
  a_irq: assert property (p_irq) else $error("irq unmasked");
  property p_flag;
    en && !ctl[3] && $fell(serial_clock_oe_n) |-> ##[0:3] irq_request;
  endproperty
  a_flag: assert property (p_flag) else $error("no irq");
  property p_rel;
    !ctl[3] && !serial_clock_oe_n && d_acc |-> ##[1:4] serial_clock_oe_n;
  endproperty
  a_rel: assert property (p_rel) else $error("clock held");
  property p_srst;
    (ctl[2] && !ctl[3])[*4] |-> serial_clock_oe_n && serial_data_oe_n;
  endproperty
  a_srst: assert property (p_srst) else $error("not idle");
  property p_stop;
    !ctl[3] && serial_clock_in && $rose(serial_data_in) |->
      ##8 serial_data_oe_n;
  endproperty
  a_stop: assert property (p_stop) else $error("stop ignored");
  // main scenarios reached
  c_str: cover property (!ctl[3] && $fell(serial_clock_oe_n));
  c_irq: cover property ($rose(irq_request));
  c_mst: cover property (m_on && !serial_clock_oe_n);
endmodule // twslv_properties
bind twslv_core twslv_properties props_u (.clk, .reset_n, .reg_addr,
  .reg_wr, .reg_rd, .reg_wdata, .spi_select_bit, .twowire_irq_enable,
  .global_irq_enable, .irq_request, .serial_data_in, .serial_data_out,
  .serial_data_oe_n, .serial_clock_in, .serial_clock_out,
  .serial_clock_oe_n);
